// ===== logic/product_unit_consts.svh
// Encoding fields, reset values and engine step size of the integer product unit
`ifndef PRODUCT_UNIT_CONSTS_SVH
`define PRODUCT_UNIT_CONSTS_SVH

// ==========================================================================
// Instruction fields
`define OPC_SPECIAL 6'h00
`define OPC_SECONDARY 6'h1C
`define FN_LEGACY_PRODUCT 6'h02
`define FN_SIGNED_PRODUCT 6'h18
`define FN_UNSIGNED_PRODUCT 6'h19
`define FN_MOVE_BOTTOM 6'h13
`define SHAMT_ZERO 5'h00
`define SHAMT_LOW_WORD 5'h02
`define SHAMT_HIGH_WORD 5'h03

// ==========================================================================
// Reset values and engine step
`define WORD_RESET 32'h0000_0000
`define PROD_RESET 64'h0000_0000_0000_0000
`define STEP_BITS 8

`endif

// ===== logic/product_unit_pkg.sv
// Types shared by the integer product unit and its engine
package product_unit_pkg;

  // ==========================================================================
  // Issued operation
  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] srcA;
    logic [63:0] srcB;
  } issue_t;

  // ==========================================================================
  // General register write-back
  typedef struct packed {
    logic [4:0] dest;
    logic [31:0] data;
  } writeback_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_MOVE_BOTTOM,
    OP_PAIR,
    OP_LEGACY,
    OP_LOW_WORD,
    OP_HIGH_WORD
  } op_kind_t;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } unit_state_t;

endpackage

// ===== logic/product_engine.sv
// Iterative 32x32 multiplier whose latency follows the second operand's size
`include "product_unit_consts.svh"
module product_engine
  import product_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  input wire logic isSigned,
  // Answer
  output logic busy,
  output logic done,
  output logic [63:0] product
);

  // ==========================================================================
  // State
  logic busy_r, busy_nxt, done_r, done_nxt, neg_r, neg_nxt;
  logic [63:0] acc_r, acc_nxt, mcand_r, mcand_nxt, prod_r, prod_nxt;
  logic [31:0] mplier_r, mplier_nxt;

  // Sign is stripped first so the early stop works on magnitudes
  always_comb begin
    logic negA;
    logic negB;
    logic [31:0] magA;
    logic [31:0] magB;
    negA = isSigned & opA[31];
    negB = isSigned & opB[31];
    magA = negA ? 32'(-opA) : opA;
    magB = negB ? 32'(-opB) : opB;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    neg_nxt = neg_r;
    acc_nxt = acc_r;
    mcand_nxt = mcand_r;
    mplier_nxt = mplier_r;
    prod_nxt = prod_r;
    if (start && !busy_r) begin
      busy_nxt = 1'b1;
      neg_nxt = negA ^ negB;
      acc_nxt = `PROD_RESET;
      mcand_nxt = {32'h0000_0000, magA};
      mplier_nxt = magB;
    end else if (busy_r) begin
      acc_nxt = 64'(acc_r + 64'(mcand_r * mplier_r[`STEP_BITS-1:0]));
      mcand_nxt = mcand_r << `STEP_BITS;
      mplier_nxt = mplier_r >> `STEP_BITS;
      // Stop as soon as no multiplier bits remain
      if (mplier_nxt == 32'h0000_0000) begin  // RULE16
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        prod_nxt = neg_r ? 64'(-acc_nxt) : acc_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      neg_r <= 1'b0;
      acc_r <= `PROD_RESET;
      mcand_r <= `PROD_RESET;
      mplier_r <= `WORD_RESET;
      prod_r <= `PROD_RESET;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      neg_r <= neg_nxt;
      acc_r <= acc_nxt;
      mcand_r <= mcand_nxt;
      mplier_r <= mplier_nxt;
      prod_r <= prod_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign product = prod_r;

  // ==========================================================================
  // Checks
  sequence runToDone;
    (start && !busy_r) ##[2:5] done_r;
  endsequence

  engine_latency_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    (start && !busy_r) |-> runToDone)
    else $error("engine result outside two to five cycles");

endmodule

// ===== logic/integer_product_hilo_unit.sv
// Integer product unit with upper and bottom product registers
`include "product_unit_consts.svh"

// Functional notes
// RULE1 - Move copies source register into bottom product
// RULE2 - Software reads pending pair result before overwriting
// RULE3 - Move after unread result may spoil upper
// RULE4 - No spacing between product read and write
// RULE5 - Legacy multiply decoded from secondary group
// RULE6 - Legacy multiply writes signed low word
// RULE7 - Multiplies never raise arithmetic exceptions
// RULE8 - Reading pending destination stalls until written
// RULE9 - Newer variants selected by shift and function
// RULE10 - Low variants return product low word
// RULE11 - High variants return product high word
// RULE12 - Operand bits above 31 are ignored
// RULE13 - Pair multiply writes bottom and upper words
// RULE14 - Sixth release rejects pair, move, legacy
// RULE15 - Matching high after low is fused
// RULE16 - Latency depends on second operand size
// RULE17 - Product reads stall during pair multiply
// RULE18 - Move and pair use special opcode
module integer_product_hilo_unit
  import product_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic release6Mode,
  // Issue
  input wire logic issueValid,
  input wire issue_t issue,
  output logic issueReady,
  output logic illegalOp,
  // General register write-back
  output logic wbValid,
  output writeback_t wb,
  // Destination interlock
  input wire logic [4:0] destQueryIdx,
  output logic destBusy,
  // Product register reads
  input wire logic prodRdValid,
  input wire logic prodRdUpper,
  output logic prodRdReady,
  output logic prodRdDone,
  output logic [31:0] prodRdData
);

  // ==========================================================================
  // Decode
  logic [5:0] opcode, func;
  logic [4:0] shamt, destIdx;
  logic [31:0] wordA, wordB;
  op_kind_t kind;
  logic kindSigned, accept;

  assign opcode = issue.instr[31:26];
  assign shamt = issue.instr[10:6];
  assign func = issue.instr[5:0];
  assign destIdx = issue.instr[15:11];
  assign wordA = issue.srcA[31:0];  // RULE12
  assign wordB = issue.srcB[31:0];  // RULE12

  always_comb begin
    kind = OP_NONE;
    kindSigned = 1'b1;
    if (opcode == `OPC_SECONDARY && func == `FN_LEGACY_PRODUCT && shamt == `SHAMT_ZERO) begin
      kind = release6Mode ? OP_NONE : OP_LEGACY;  // RULE5 RULE14
    end else if (opcode == `OPC_SPECIAL && func == `FN_MOVE_BOTTOM) begin
      kind = release6Mode ? OP_NONE : OP_MOVE_BOTTOM;  // RULE18 RULE14
    end else if (opcode == `OPC_SPECIAL
                 && (func == `FN_SIGNED_PRODUCT || func == `FN_UNSIGNED_PRODUCT)) begin
      kindSigned = (func == `FN_SIGNED_PRODUCT);  // RULE9
      if (shamt == `SHAMT_ZERO) begin
        kind = release6Mode ? OP_NONE : OP_PAIR;  // RULE18 RULE14
      end else if (shamt == `SHAMT_LOW_WORD) begin
        kind = OP_LOW_WORD;  // RULE9
      end else if (shamt == `SHAMT_HIGH_WORD) begin
        kind = OP_HIGH_WORD;  // RULE9
      end
    end
  end

  // ==========================================================================
  // Engine
  logic coreStart, coreDone, fuseHit;
  logic [63:0] coreProd;

  product_engine engine (
    .clk(clk),
    .rst_n(rst_n),
    .start(coreStart),
    .opA(wordA),
    .opB(wordB),
    .isSigned(kindSigned),
    .busy(),
    .done(coreDone),
    .product(coreProd)
  );

  // ==========================================================================
  // Control and product registers
  unit_state_t state_r, state_nxt;
  op_kind_t runKind_r, runKind_nxt;
  logic [4:0] runDest_r, runDest_nxt;
  logic [31:0] upper_r, upper_nxt, bottom_r, bottom_nxt;
  logic unread_r, unread_nxt, illegal_r, illegal_nxt;
  logic wbValid_r, wbValid_nxt, rdDone_r, rdDone_nxt;
  writeback_t wb_r, wb_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic lastValid_r, lastValid_nxt, lastSigned_r, lastSigned_nxt;
  logic [31:0] lastA_r, lastA_nxt, lastB_r, lastB_nxt;
  logic [63:0] lastProd_r, lastProd_nxt;
  logic pairRunning, rdAccept;

  // Only one operation in flight keeps the interlock small
  assign issueReady = (state_r == ST_IDLE);
  assign accept = issueValid && issueReady;
  assign pairRunning = (state_r == ST_RUN) && (runKind_r == OP_PAIR);
  assign prodRdReady = !pairRunning;  // RULE17 RULE4
  assign rdAccept = prodRdValid && prodRdReady;
  assign destBusy = (state_r == ST_RUN) && (runKind_r != OP_PAIR)
                    && (runDest_r == destQueryIdx);  // RULE8
  assign fuseHit = (kind == OP_HIGH_WORD) && lastValid_r && lastSigned_r == kindSigned
                   && lastA_r == wordA && lastB_r == wordB;  // RULE15
  assign coreStart = accept && !fuseHit
                     && (kind == OP_PAIR || kind == OP_LEGACY
                         || kind == OP_LOW_WORD || kind == OP_HIGH_WORD);

  always_comb begin
    state_nxt = state_r;
    runKind_nxt = runKind_r;
    runDest_nxt = runDest_r;
    upper_nxt = upper_r;
    bottom_nxt = bottom_r;
    unread_nxt = unread_r;
    illegal_nxt = 1'b0;
    wbValid_nxt = 1'b0;
    wb_nxt = wb_r;
    rdDone_nxt = 1'b0;
    rdData_nxt = rdData_r;
    lastValid_nxt = lastValid_r;
    lastSigned_nxt = lastSigned_r;
    lastA_nxt = lastA_r;
    lastB_nxt = lastB_r;
    lastProd_nxt = lastProd_r;
    // Reads take the old value even beside a write in the same cycle
    if (rdAccept) begin
      rdDone_nxt = 1'b1;
      rdData_nxt = prodRdUpper ? upper_r : bottom_r;
      unread_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          lastValid_nxt = 1'b0;
          runKind_nxt = kind;
          runDest_nxt = destIdx;
          // Only undecodable or removed encodings trap, never overflow
          if (kind == OP_NONE) begin
            illegal_nxt = 1'b1;  // RULE7 RULE14
          end else if (kind == OP_MOVE_BOTTOM) begin
            bottom_nxt = wordA;  // RULE1
            // Upper keeps whatever it held, which is allowed to be stale
            unread_nxt = 1'b0;  // RULE3
          end else if (fuseHit) begin
            wbValid_nxt = 1'b1;  // RULE15
            wb_nxt = '{dest: destIdx, data: lastProd_r[63:32]};
          end else begin
            state_nxt = ST_RUN;
            if (kind == OP_LOW_WORD) begin
              lastValid_nxt = 1'b1;
              lastSigned_nxt = kindSigned;
              lastA_nxt = wordA;
              lastB_nxt = wordB;
            end
          end
        end
      end
      ST_RUN: begin
        if (coreDone) begin
          state_nxt = ST_IDLE;
          if (runKind_r == OP_PAIR) begin
            bottom_nxt = coreProd[31:0];  // RULE13
            upper_nxt = coreProd[63:32];  // RULE13
            unread_nxt = 1'b1;
          end else begin
            wbValid_nxt = 1'b1;
            wb_nxt.dest = runDest_r;
            // Legacy form leaves both product registers as they were
            if (runKind_r == OP_HIGH_WORD) begin
              wb_nxt.data = coreProd[63:32];  // RULE11
            end else begin
              wb_nxt.data = coreProd[31:0];  // RULE6 RULE10
            end
            lastProd_nxt = coreProd;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      runKind_r <= OP_NONE;
      runDest_r <= 5'h00;
      upper_r <= `WORD_RESET;
      bottom_r <= `WORD_RESET;
      unread_r <= 1'b0;
      illegal_r <= 1'b0;
      wbValid_r <= 1'b0;
      wb_r <= '0;
      rdDone_r <= 1'b0;
      rdData_r <= `WORD_RESET;
      lastValid_r <= 1'b0;
      lastSigned_r <= 1'b0;
      lastA_r <= `WORD_RESET;
      lastB_r <= `WORD_RESET;
      lastProd_r <= `PROD_RESET;
    end else begin
      state_r <= state_nxt;
      runKind_r <= runKind_nxt;
      runDest_r <= runDest_nxt;
      upper_r <= upper_nxt;
      bottom_r <= bottom_nxt;
      unread_r <= unread_nxt;
      illegal_r <= illegal_nxt;
      wbValid_r <= wbValid_nxt;
      wb_r <= wb_nxt;
      rdDone_r <= rdDone_nxt;
      rdData_r <= rdData_nxt;
      lastValid_r <= lastValid_nxt;
      lastSigned_r <= lastSigned_nxt;
      lastA_r <= lastA_nxt;
      lastB_r <= lastB_nxt;
      lastProd_r <= lastProd_nxt;
    end
  end

  assign illegalOp = illegal_r;
  assign wbValid = wbValid_r;
  assign wb = wb_r;
  assign prodRdDone = rdDone_r;
  assign prodRdData = rdData_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence pairFinish;
    (state_r == ST_RUN) && (runKind_r == OP_PAIR) && coreDone;
  endsequence

  sequence wordFinish;
    (state_r == ST_RUN) && (runKind_r != OP_PAIR) && coreDone;
  endsequence

  move_bottom_a: assert property ( // RULE1
    (accept && kind == OP_MOVE_BOTTOM) |=> (bottom_r == $past(issue.srcA[31:0])))
    else $error("move did not load bottom product");
  pair_write_a: assert property ( // RULE13
    pairFinish |=> ({upper_r, bottom_r} == $past(coreProd)) && !wbValid_r)
    else $error("pair product not split into registers");
  low_word_a: assert property ( // RULE10
    (wordFinish and (runKind_r != OP_HIGH_WORD)) |=> wbValid_r
      && wb_r.data == $past(coreProd[31:0]) && wb_r.dest == $past(runDest_r))
    else $error("low word write-back wrong");
  high_word_a: assert property ( // RULE11
    (wordFinish and (runKind_r == OP_HIGH_WORD)) |=> wbValid_r
      && wb_r.data == $past(coreProd[63:32]))
    else $error("high word write-back wrong");
  removed_ops_a: assert property ( // RULE14
    (accept && release6Mode && opcode == `OPC_SPECIAL && func == `FN_MOVE_BOTTOM)
      |=> illegalOp && $stable(bottom_r))
    else $error("removed move accepted in sixth release");
  read_stall_a: assert property ( // RULE17
    (prodRdValid && pairRunning) |=> !prodRdDone)
    else $error("product read not stalled");
  dest_stall_a: assert property ( // RULE8
    (accept && coreStart && kind != OP_PAIR)
      |=> destBusy == (destQueryIdx == $past(destIdx)))
    else $error("pending destination not interlocked");
  fuse_pair_a: assert property ( // RULE15
    (accept && fuseHit) |=> wbValid_r && wb_r.data == $past(lastProd_r[63:32]))
    else $error("fused high word not returned next cycle");
  read_free_a: assert property ( // RULE4
    (prodRdValid && state_r == ST_IDLE) |-> prodRdReady ##1 prodRdDone)
    else $error("product read delayed without a pair running");
  move_unread_a: assert property ( // RULE3
    (accept && kind == OP_MOVE_BOTTOM) |=> !unread_r && $stable(upper_r))
    else $error("move disturbed upper product or unread mark");
  no_trap_a: assert property ( // RULE7
    (accept && kind != OP_NONE) |=> !illegalOp)
    else $error("legal multiply raised a trap");

endmodule

// ===== sim/pipeline_model.sv
// Model of the instruction pipeline that issues products and reads the pair
module pipeline_model
  import product_unit_pkg::*;
(
  // Clock
  input wire logic clk,
  // Issue side
  input wire logic issueReady,
  output logic issueValid,
  output issue_t issue,
  // Product register reads
  input wire logic prodRdReady,
  output logic prodRdValid,
  output logic prodRdUpper
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    issueValid = 1'b0;
    issue = '0;
    prodRdValid = 1'b0;
    prodRdUpper = 1'b0;
  end

  // ==========================================================================
  // Request held until taken; released fields scrambled so stale data shows
  task automatic send(input logic [31:0] instr, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk);
    issueValid <= 1'b1;
    issue <= '{instr: instr, srcA: a, srcB: b};
    do @(negedge clk); while (issueReady !== 1'b1);
    @(posedge clk);
    issueValid <= 1'b0;
    issue <= ~issue;
  endtask

  // ==========================================================================
  // Pair read; scenarios call it after each pair multiply and again after a move
  task automatic fetch(input logic upper);
    @(posedge clk);
    prodRdValid <= 1'b1;
    prodRdUpper <= upper;
    do @(negedge clk); while (prodRdReady !== 1'b1);
    @(posedge clk);
    prodRdValid <= 1'b0;
    prodRdUpper <= ~upper;
  endtask
endmodule

// ===== sim/integer_product_hilo_unit_tb.sv
// Self-checking bench of the integer product unit
`include "product_unit_consts.svh"
module integer_product_hilo_unit_tb
  import product_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, release6Mode, issueValid, issueReady, illegalOp, wbValid;
  logic destBusy, prodRdValid, prodRdUpper, prodRdReady, prodRdDone;
  issue_t issue;
  writeback_t wb;
  logic [4:0] destQueryIdx;
  logic [31:0] prodRdData;
  int failCount = 0;
  int nCompared = 0;
  int cycles = 0;

  integer_product_hilo_unit DUT (.clk(clk), .rst_n(rst_n), .release6Mode(release6Mode),
    .issueValid(issueValid), .issue(issue), .issueReady(issueReady), .illegalOp(illegalOp),
    .wbValid(wbValid), .wb(wb), .destQueryIdx(destQueryIdx), .destBusy(destBusy),
    .prodRdValid(prodRdValid), .prodRdUpper(prodRdUpper), .prodRdReady(prodRdReady),
    .prodRdDone(prodRdDone), .prodRdData(prodRdData));

  pipeline_model pipe (.clk(clk), .issueReady(issueReady), .issueValid(issueValid),
    .issue(issue), .prodRdReady(prodRdReady), .prodRdValid(prodRdValid),
    .prodRdUpper(prodRdUpper));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Generous ceiling; the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] enc(logic [5:0] op, logic [4:0] d, logic [4:0] sh,
    logic [5:0] fn);
    return {op, 5'h01, 5'h02, d, sh, fn};
  endfunction

  function automatic logic [63:0] mulx(logic [31:0] a, logic [31:0] b, logic s);
    if (s) return {{32{a[31]}}, a} * {{32{b[31]}}, b};
    return {32'h0000_0000, a} * {32'h0000_0000, b};
  endfunction

  task automatic waitFlag(input logic sel, output int lat);
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while ((sel ? illegalOp : wbValid) !== 1'b1 && lat < 20);
    chk(sel ? illegalOp : wbValid, 64'h1);
  endtask

  task automatic readChk(input logic upper, input logic [31:0] exp);
    pipe.fetch(upper);
    @(negedge clk);
    chk(prodRdDone, 64'h1);
    chk(prodRdData, exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic wordVariants();
    logic [63:0] p;
    int lat;
    for (int v = 0; v < 4; v++) begin
      p = mulx(32'hFFFF_FFF3, 32'h8000_0005, v < 2);
      pipe.send(enc(`OPC_SPECIAL, 5'h07, v[0] ? `SHAMT_HIGH_WORD : `SHAMT_LOW_WORD,
        v < 2 ? `FN_SIGNED_PRODUCT : `FN_UNSIGNED_PRODUCT),
        {32'hDEAD_BEEF, 32'hFFFF_FFF3}, {32'h1234_5678, 32'h8000_0005});
      if (!v[0]) begin
        @(negedge clk);
        chk(destBusy, 64'h1);
        chk(issueReady, 64'h0);
      end
      waitFlag(1'b0, lat);
      chk(wb.data, v[0] ? p[63:32] : p[31:0]);
      chk(wb.dest, 64'h7);
      chk(destBusy, 64'h0);
    end
  endtask

  task automatic latencyBySize();
    int l1, l2;
    pipe.send(enc(`OPC_SPECIAL, 5'h03, `SHAMT_LOW_WORD, `FN_SIGNED_PRODUCT), 64'h9, 64'h5);
    waitFlag(1'b0, l1);
    pipe.send(enc(`OPC_SPECIAL, 5'h03, `SHAMT_LOW_WORD, `FN_SIGNED_PRODUCT), 64'h9,
      64'h7FFF_FFFF);
    waitFlag(1'b0, l2);
    chk(l2 - l1, 64'h3);
  endtask

  task automatic pairAndMove();
    logic [63:0] p;
    for (int s = 0; s < 2; s++) begin
      p = mulx(32'h8000_0003, 32'hFFFF_FFFE, s == 0);
      pipe.send(enc(`OPC_SPECIAL, 5'h00, `SHAMT_ZERO,
        s == 0 ? `FN_SIGNED_PRODUCT : `FN_UNSIGNED_PRODUCT),
        64'h8000_0003, 64'hFFFF_FFFE);
      @(negedge clk);
      chk(prodRdReady, 64'h0);
      readChk(1'b0, p[31:0]);
      readChk(1'b1, p[63:32]);
      // Write straight after a read, no spacing
      pipe.send(enc(`OPC_SPECIAL, 5'h00, `SHAMT_ZERO, `FN_MOVE_BOTTOM),
        {32'h1234_5678, 32'hCAFE_F00D}, 64'h0);
      readChk(1'b0, 32'hCAFE_F00D);
      readChk(1'b1, p[63:32]);
    end
  endtask

  task automatic legacyForm();
    int lat;
    pipe.send(enc(`OPC_SECONDARY, 5'h09, `SHAMT_ZERO, `FN_LEGACY_PRODUCT),
      64'h7FFF_FFF9, 64'h6);
    waitFlag(1'b0, lat);
    chk(wb.data, 64'hFFFF_FFD6);
    chk(wb.dest, 64'h9);
  endtask

  task automatic release6Refusals();
    logic [31:0] bad [3];
    int lat;
    bad[0] = enc(`OPC_SPECIAL, 5'h00, `SHAMT_ZERO, `FN_SIGNED_PRODUCT);
    bad[1] = enc(`OPC_SPECIAL, 5'h00, `SHAMT_ZERO, `FN_MOVE_BOTTOM);
    bad[2] = enc(`OPC_SECONDARY, 5'h09, `SHAMT_ZERO, `FN_LEGACY_PRODUCT);
    @(posedge clk);
    release6Mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pipe.send(bad[i], 64'h3, 64'h4);
      waitFlag(1'b1, lat);
    end
    pipe.send(enc(`OPC_SPECIAL, 5'h04, `SHAMT_LOW_WORD, `FN_UNSIGNED_PRODUCT), 64'h3, 64'h4);
    waitFlag(1'b0, lat);
    chk(wb.data, 64'hC);
    @(posedge clk);
    release6Mode <= 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    release6Mode = 1'b0;
    destQueryIdx = 5'h07;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wordVariants();
    latencyBySize();
    pairAndMove();
    legacyForm();
    release6Refusals();
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
